// *** core/bitmode_pkg.sv ***
// constants for the per-channel mode logic: mode codes, register map, timing
// assumes a 10 MHz core clock and an AXI4-Lite register bus
package bitmode_pkg;
   // mode-set values written by software
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE_ASYNC_BB = 8'h01;
   localparam logic [7:0] MODE_ENGINE = 8'h02;
   localparam logic [7:0] MODE_SYNC_BB = 8'h04;
   typedef enum logic [1:0] {OP_IDLE, OP_ASYNC, OP_ENGINE, OP_SYNC} op_type;
   // register byte addresses
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_DIR = 8'h04;
   localparam logic [7:0] ADDR_BAUD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_PINS = 8'h10;
   localparam logic [7:0] ADDR_ENGCFG = 8'h14;
   // baud register fields
   localparam int BAUD_INT_W = 14;
   localparam int BAUD_FRAC_W = 4;
   localparam logic [17:0] BAUD_RESET = 18'h00010;
   // engine config fields
   localparam int ENG_ADAPT_BIT = 0;
   localparam int ENG_DIV_LSB = 8;
   localparam int ENG_DIV_W = 8;
   localparam logic [7:0] RETURNED_CLOCK_BIT = 8'h03;
   // serial clock: 30 MHz ceiling, 33.33 ns nominal period
   localparam real SCLK_MAX_MHZ = 30.0;
   localparam real SCLK_PERIOD_NS = 33.33;
   localparam real MCLK_PERIOD_NS = 100.0;
   // half period never below one core cycle, so the output stays far under its ceiling
   localparam int SCLK_MIN_HALF = (int'(SCLK_PERIOD_NS / 2.0 / MCLK_PERIOD_NS) < 1) ? 1 :
      int'(SCLK_PERIOD_NS / 2.0 / MCLK_PERIOD_NS);
   localparam int SYNC_SETUP_CYCLES = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bitmode_pkg

// *** core/bitmode_channel.sv ***
// one bridge channel: mode selection, bit-bang parallel port and a serial engine shell
// assumes byte streams from/to the usb buffers with valid/ready, pins from off-chip
// Notes on behaviour
// - mode 2 enables the serial engine; mode 0 resets channel mode logic.
// - mode 1 selects asynchronous bit-bang.
// - mode 4 selects synchronous bit-bang.
// - serial engine exists only on channels 0 and 1.
// - engine is configured and run only by command bytes in the host stream; here divider and adaptive flag are set through the ENGCFG register.
// - engine sustains up to 30 Mbit/s serial transfers; here the 10 MHz core limits the serial clock to 5 MHz.
// - serial clock at most 30 MHz, slower rates by an internal divider.
// - adaptive clocking raises clock, waits for returned clock on gpio bit3, then changes data.
// - adaptive clocking is off after reset, on only when commanded.
// - every channel can act as sync or async bit-bang port.
// - each pin individually input or output; data drives output pins only.
// - async bit-bang places host bytes on pins at the baud tick rate.
// - async outputs change only with pending data and a tick, else hold.
// - sync bit-bang updates pins and samples inputs only when a byte is taken.
// - sync bit-bang proceeds only when the transmit buffer has room.
// - pins sampled before driving, so returned data lags one byte; here bytes taken two cycles apart return pins from two bytes back.
// - sync cycle: read pins, forward, drive new value, one setup cycle.
// - no read or write strobe pins are driven in bit-bang.
// - baud tick from 120 MHz reference, 14-bit prescaler plus fraction.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bitmode_channel #(
   parameter int CHANNEL_INDEX = 0,
   parameter int PORT_W = 8
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // 120 MHz-derived reference enable, one cycle per reference tick
   input wire logic ref_tick_in,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // usb receive buffer (host to device)
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   // usb transmit buffer (device to host)
   output logic [7:0] tx_data_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   // parallel pins
   input wire logic [PORT_W-1:0] pins_in,
   output logic [PORT_W-1:0] pins_out,
   output logic [PORT_W-1:0] pins_oe_out,
   // serial engine pins
   output logic serial_clock_out,
   output logic serial_data_out,
   // engine command bytes handed to the external command decoder
   output logic [7:0] engine_cmd_out,
   output logic engine_cmd_valid_out
);
   localparam bit HAS_ENGINE = (CHANNEL_INDEX < 2);

   bitmode_pkg::op_type op_reg;
   logic [PORT_W-1:0] dir_reg;
   logic [17:0] baud_reg;
   logic adapt_reg;
   logic [bitmode_pkg::ENG_DIV_W-1:0] div_reg;
   logic [PORT_W-1:0] pin_s1_reg, pin_s2_reg;
   logic [PORT_W-1:0] out_reg;
   logic [7:0] pend_reg;
   logic pend_valid_reg;
   logic [7:0] tx_reg;
   logic tx_valid_reg;
   logic setup_reg;

   // pin synchroniser: only the second stage is read
   // no reset: pins settle alone
   always_ff @(posedge mclk_in) begin
      pin_s1_reg <= pins_in;
      pin_s2_reg <= pin_s1_reg;
   end

   // register bus: single outstanding write and read
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign do_write = aw_hold_reg && w_hold_reg;
   // no new halves while bvalid stands

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // unmapped writes get an error
   logic addr_ok_w;
   always_comb begin
      unique case (aw_addr_reg)
         bitmode_pkg::ADDR_MODE, bitmode_pkg::ADDR_DIR, bitmode_pkg::ADDR_BAUD,
         bitmode_pkg::ADDR_STATUS, bitmode_pkg::ADDR_PINS, bitmode_pkg::ADDR_ENGCFG: addr_ok_w = 1'b1;
         default: addr_ok_w = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= bitmode_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_ok_w ? bitmode_pkg::RESP_OKAY : bitmode_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // mode register: unknown codes and engine on channels without one are refused
   // a refused code keeps the mode
   logic wr_mode;
   assign wr_mode = do_write && aw_addr_reg == bitmode_pkg::ADDR_MODE && w_strb_reg[0];
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         op_reg <= bitmode_pkg::OP_IDLE;
      end else if (wr_mode) begin
         unique case (w_data_reg[7:0])
            bitmode_pkg::MODE_RESET: op_reg <= bitmode_pkg::OP_IDLE;
            bitmode_pkg::MODE_ENGINE: op_reg <= HAS_ENGINE ? bitmode_pkg::OP_ENGINE : op_reg;
            bitmode_pkg::MODE_ASYNC_BB: op_reg <= bitmode_pkg::OP_ASYNC;
            bitmode_pkg::MODE_SYNC_BB: op_reg <= bitmode_pkg::OP_SYNC;
            default: op_reg <= op_reg;
         endcase
      end
   end
   logic mode_reset;
   assign mode_reset = wr_mode && w_data_reg[7:0] == bitmode_pkg::MODE_RESET;
   // mode 0 keeps direction and baud

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         dir_reg <= '0;
      end else if (do_write && aw_addr_reg == bitmode_pkg::ADDR_DIR && w_strb_reg[0]) begin
         // 1 marks an output pin
         dir_reg <= w_data_reg[PORT_W-1:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         baud_reg <= bitmode_pkg::BAUD_RESET;
      end else if (do_write && aw_addr_reg == bitmode_pkg::ADDR_BAUD) begin
         // strobes ignored: written whole
         baud_reg <= w_data_reg[17:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         adapt_reg <= 1'b0;
         div_reg <= '0;
      end else if (do_write && aw_addr_reg == bitmode_pkg::ADDR_ENGCFG && HAS_ENGINE) begin
         // only where an engine exists
         adapt_reg <= w_data_reg[bitmode_pkg::ENG_ADAPT_BIT];
         div_reg <= w_data_reg[bitmode_pkg::ENG_DIV_LSB +: bitmode_pkg::ENG_DIV_W];
      end
   end

   // read side
   // answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= bitmode_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= bitmode_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            bitmode_pkg::ADDR_MODE: s_axi_rdata <= {30'h0, op_reg};
            bitmode_pkg::ADDR_DIR: s_axi_rdata <= 32'(dir_reg);
            bitmode_pkg::ADDR_BAUD: s_axi_rdata <= {14'h0, baud_reg};
            bitmode_pkg::ADDR_STATUS: s_axi_rdata <= {28'h0, HAS_ENGINE, setup_reg, pend_valid_reg, tx_valid_reg};
            bitmode_pkg::ADDR_PINS: s_axi_rdata <= 32'(pin_s2_reg);
            bitmode_pkg::ADDR_ENGCFG: s_axi_rdata <= {16'h0, div_reg, 7'h0, adapt_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= bitmode_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // baud generator: integer plus sixteenths, counted in reference ticks
   // reset value ticks on every reference tick
   localparam int BAUD_ACC_W = bitmode_pkg::BAUD_INT_W + bitmode_pkg::BAUD_FRAC_W;
   logic [BAUD_ACC_W-1:0] baud_cnt_reg;
   logic baud_tick;
   logic [BAUD_ACC_W-1:0] baud_step;
   assign baud_step = {{(BAUD_ACC_W-1){1'b0}}, 1'b1} << bitmode_pkg::BAUD_FRAC_W;
   assign baud_tick = ref_tick_in && (baud_cnt_reg + baud_step >= baud_reg);
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         baud_cnt_reg <= '0;
      end else if (ref_tick_in) begin
         baud_cnt_reg <= baud_tick ? BAUD_ACC_W'(baud_cnt_reg + baud_step - baud_reg) :
            BAUD_ACC_W'(baud_cnt_reg + baud_step);
      end
   end

   // byte intake from the receive buffer
   // sync waits for a free tx slot
   logic sync_take, async_take, eng_take;
   assign async_take = op_reg == bitmode_pkg::OP_ASYNC && !pend_valid_reg && rx_valid_in;
   assign sync_take = op_reg == bitmode_pkg::OP_SYNC && rx_valid_in && !tx_valid_reg && !setup_reg;
   assign eng_take = op_reg == bitmode_pkg::OP_ENGINE && rx_valid_in;
   assign rx_ready_out = (op_reg == bitmode_pkg::OP_ASYNC && !pend_valid_reg) || sync_take || eng_take;

   // asynchronous bit-bang holding byte
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         pend_valid_reg <= 1'b0;
         pend_reg <= 8'h00;
      end else if (async_take) begin
         pend_valid_reg <= 1'b1;
         pend_reg <= rx_data_in;
      end else if (pend_valid_reg && baud_tick) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // output latch: one host byte maps onto the eight pins
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         out_reg <= '0;
      end else if (op_reg == bitmode_pkg::OP_ASYNC && pend_valid_reg && baud_tick) begin
         out_reg <= pend_reg[PORT_W-1:0];
      end else if (sync_take) begin
         out_reg <= rx_data_in[PORT_W-1:0];
      end
   end

   // sync capture: pins read before the new byte lands, hence one byte behind, or two when bytes are taken two cycles apart
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         tx_valid_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else if (sync_take) begin
         tx_valid_reg <= 1'b1;
         tx_reg <= 8'(pin_s2_reg);
      end else if (tx_ready_in) begin
         tx_valid_reg <= 1'b0;
      end
   end
   // slot frees on tx_ready_in
   assign tx_valid_out = tx_valid_reg;
   assign tx_data_out = tx_reg;

   // one setup cycle after each drive before the next byte
   // limitation: one core cycle only
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         setup_reg <= 1'b0;
      end else begin
         setup_reg <= sync_take;
      end
   end

   // only bit-bang modes drive parallel pins, and only those set as outputs; no strobe pins exist
   logic bb_active;
   assign bb_active = op_reg == bitmode_pkg::OP_ASYNC || op_reg == bitmode_pkg::OP_SYNC;
   // gated: no stale latch in engine mode
   assign pins_out = bb_active ? out_reg & dir_reg : '0;
   assign pins_oe_out = bb_active ? dir_reg : '0;

   // serial engine shell: command bytes are forwarded verbatim to the decoder
   // one pulse per forwarded byte
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset) begin
         engine_cmd_valid_out <= 1'b0;
         engine_cmd_out <= 8'h00;
      end else begin
         engine_cmd_valid_out <= eng_take;
         if (eng_take) begin
            engine_cmd_out <= rx_data_in;
         end
      end
   end

   // serial clock divider; the 10 MHz core keeps the rate below the 30 MHz ceiling
   // div 0: one core cycle per half
   logic [bitmode_pkg::ENG_DIV_W-1:0] half_cnt_reg;
   logic sclk_reg, sdata_reg, wait_returned_clock_reg;
   logic returned_clock_w;
   logic half_done;
   assign returned_clock_w = pin_s2_reg[bitmode_pkg::RETURNED_CLOCK_BIT[2:0]];
   // act on a fresh rise only
   logic returned_clock_last_reg;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         returned_clock_last_reg <= 1'b0;
      end else begin
         returned_clock_last_reg <= returned_clock_w;
      end
   end

   assign half_done = half_cnt_reg >= div_reg + bitmode_pkg::ENG_DIV_W'(bitmode_pkg::SCLK_MIN_HALF - 1);
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || mode_reset || op_reg != bitmode_pkg::OP_ENGINE) begin
         half_cnt_reg <= '0;
         sclk_reg <= 1'b0;
         sdata_reg <= 1'b0;
         wait_returned_clock_reg <= 1'b0;
      end else if (wait_returned_clock_reg) begin
         // no timeout by design
         if (returned_clock_w && !returned_clock_last_reg) begin
            wait_returned_clock_reg <= 1'b0;
            sdata_reg <= engine_cmd_out[0];
         end
      end else if (half_done) begin
         half_cnt_reg <= '0;
         sclk_reg <= !sclk_reg;
         if (!sclk_reg && adapt_reg) begin
            wait_returned_clock_reg <= 1'b1;
         end else if (sclk_reg && !adapt_reg) begin
            sdata_reg <= engine_cmd_out[0];
         end
      end else begin
         half_cnt_reg <= half_cnt_reg + 1'b1;
      end
   end
   assign serial_clock_out = sclk_reg;
   assign serial_data_out = sdata_reg;
endmodule : bitmode_channel
`default_nettype wire

// *** testbench/bitmode_channel_properties.sv ***
// port checker for one bridge channel: bus answers, pin masking, engine presence
// assumes a single clock domain and binding onto bitmode_channel
`timescale 1ns/1ps
`default_nettype none
module bitmode_channel_properties #(
   parameter int CHANNEL_INDEX = 0,
   parameter int PORT_W = 8
) (
   // clock, reset and reference tick
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ref_tick_in,
   // bus
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // byte streams
   input wire logic rx_valid_in,
   input wire logic rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   // pins and engine
   input wire logic [PORT_W-1:0] pins_out,
   input wire logic [PORT_W-1:0] pins_oe_out,
   input wire logic engine_cmd_valid_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   oe_mask_a: assert property ((pins_out & ~pins_oe_out) == '0)
      else $error("pin value on an input pin");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("returned byte lost");
   engine_absent_a: assert property (CHANNEL_INDEX >= 2 |-> !engine_cmd_valid_out)
      else $error("engine active on a channel without one");
   engine_no_oe_a: assert property (engine_cmd_valid_out |-> pins_oe_out == '0)
      else $error("parallel pins enabled in engine mode");
   // a pin change with steady direction needs a tick, a taken byte or a register write behind it
   pins_cause_a: assert property ($changed(pins_out) && $stable(pins_oe_out) |-> $past(ref_tick_in)
      || $past(rx_valid_in && rx_ready_out) || $past(rx_valid_in && rx_ready_out, 2)
      || $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("pins changed without cause");
   reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=> !tx_valid_out && pins_oe_out == '0)
      else $error("outputs not cleared by reset");
   cover property (rx_valid_in && rx_ready_out && pins_oe_out != '0);
   cover property (engine_cmd_valid_out);
   cover property (tx_valid_out && !tx_ready_in);
endmodule : bitmode_channel_properties
bind bitmode_channel bitmode_channel_properties #(.CHANNEL_INDEX(CHANNEL_INDEX), .PORT_W(PORT_W)) u_props (
   .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ref_tick_in(ref_tick_in),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid_in(rx_valid_in),
   .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
   .tx_ready_in(tx_ready_in), .pins_out(pins_out), .pins_oe_out(pins_oe_out),
   .engine_cmd_valid_out(engine_cmd_valid_out));
`default_nettype wire

// *** testbench/pin_peer.sv ***
// parallel peripheral model: resolves each pin from both drivers
// assumes ext_in is what the peripheral shows on pins the channel leaves as inputs
`timescale 1ns/1ps
`default_nettype none
module pin_peer (
   // channel side
   input wire logic [7:0] pins_out,
   input wire logic [7:0] pins_oe_out,
   input wire logic serial_clock_out,
   // peripheral side
   input wire logic [7:0] ext_in,
   input wire logic returned_clock_en_in,
   output logic [7:0] pins_in
);
   // output pins read back what the channel drives, the rest show the peripheral
   assign pins_in[7:4] = (pins_out[7:4] & pins_oe_out[7:4]) | (ext_in[7:4] & ~pins_oe_out[7:4]);
   assign pins_in[2:0] = (pins_out[2:0] & pins_oe_out[2:0]) | (ext_in[2:0] & ~pins_oe_out[2:0]);
   // target echoes the serial clock on bit 3 when that pin is an input
   assign pins_in[3] = pins_oe_out[3] ? pins_out[3] : (ext_in[3] | (returned_clock_en_in & serial_clock_out));
endmodule : pin_peer
`default_nettype wire

// *** testbench/serial_engine_bitbang_modes_tb.sv ***
// self-checking bench for one channel: registers, bit-bang modes, engine forwarding
// assumes the bound port checker and the pin_peer model
`timescale 1ns/1ps
`default_nettype none
module serial_engine_bitbang_modes_tb;
   logic mclk_in, rst_n_in, ref_tick_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in, serial_clock_out, serial_data_out;
   logic engine_cmd_valid_out, returned_clock_en;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data_in, tx_data_out, pins_in, pins_out, pins_oe_out;
   logic [7:0] engine_cmd_out, ext, last_cmd, b;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int n_errors = 0;
   int checked = 0;
   bitmode_channel #(.CHANNEL_INDEX(0), .PORT_W(8)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .ref_tick_in(ref_tick_in), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
      .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
      .pins_in(pins_in), .pins_out(pins_out), .pins_oe_out(pins_oe_out),
      .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
      .engine_cmd_out(engine_cmd_out), .engine_cmd_valid_out(engine_cmd_valid_out));
   pin_peer u_peer (.pins_out(pins_out), .pins_oe_out(pins_oe_out), .serial_clock_out(serial_clock_out),
      .ext_in(ext), .returned_clock_en_in(returned_clock_en), .pins_in(pins_in));
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   // the engine strobe lasts one cycle, so it is caught here rather than by polling
   always @(posedge mclk_in) begin
      if (engine_cmd_valid_out === 1'b1) last_cmd <= engine_cmd_out;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // handshakes are judged at the falling edge, where ready and valid have settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w, bh;
      @(posedge mclk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge mclk_in);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         @(posedge mclk_in);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!bh);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic ar, rh;
      @(posedge mclk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge mclk_in);
         ar = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         v = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge mclk_in);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!rh);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic rx_wait();
      logic hs;
      do begin
         @(negedge mclk_in);
         hs = rx_ready_out;
         @(posedge mclk_in);
      end while (!hs);
      rx_valid_in <= 1'b0;
   endtask : rx_wait
   task automatic rx_send(input logic [7:0] v);
      @(posedge mclk_in);
      rx_data_in <= v;
      rx_valid_in <= 1'b1;
      rx_wait();
   endtask : rx_send
   task automatic get_tx(output logic [7:0] v);
      logic hs;
      @(posedge mclk_in);
      tx_ready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         hs = tx_valid_out;
         v = tx_data_out;
         @(posedge mclk_in);
      end while (!hs);
      tx_ready_in <= 1'b0;
   endtask : get_tx
   task automatic t_reset();
      axi_rd(bitmode_pkg::ADDR_BAUD, d, r);
      check("baud reset", d, 32'h00000010);
      axi_rd(bitmode_pkg::ADDR_ENGCFG, d, r);
      check("adaptive off", d[0], 1'b0);
      axi_rd(8'h20, d, r);
      check("unmapped resp", r, bitmode_pkg::RESP_SLVERR);
   endtask : t_reset
   task automatic t_modes();
      logic [7:0] m [4] = '{bitmode_pkg::MODE_ASYNC_BB, bitmode_pkg::MODE_ENGINE, bitmode_pkg::MODE_SYNC_BB,
         bitmode_pkg::MODE_RESET};
      logic [31:0] e [4] = '{32'h00000001, 32'h00000002, 32'h00000003, 32'h00000000};
      for (int i = 0; i < 4; i++) begin
         axi_wr(bitmode_pkg::ADDR_MODE, {24'h000000, m[i]});
         axi_rd(bitmode_pkg::ADDR_MODE, d, r);
         check("mode", d, e[i]);
      end
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000001);
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000003);
      axi_rd(bitmode_pkg::ADDR_MODE, d, r);
      check("mode kept", d, 32'h00000001);
   endtask : t_modes
   task automatic t_sync();
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000000);
      axi_wr(bitmode_pkg::ADDR_DIR, 32'h0000000f);
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000004);
      repeat (5) @(posedge mclk_in);
      rx_send(8'h55);
      @(posedge mclk_in);
      rx_data_in <= 8'h3c;
      rx_valid_in <= 1'b1;
      repeat (10) begin
         @(negedge mclk_in);
         check("rx_ready full", rx_ready_out, 1'b0);
      end
      check("pins 55", pins_out, 8'h05);
      get_tx(b);
      check("tx first", b, 8'ha0);
      rx_wait();
      get_tx(b);
      check("tx second", b, 8'ha5);
      @(negedge mclk_in);
      check("pins 3c", pins_out, 8'h0c);
   endtask : t_sync
   task automatic t_async();
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000000);
      @(negedge mclk_in);
      check("oe cleared", pins_oe_out, 8'h00);
      axi_wr(bitmode_pkg::ADDR_DIR, 32'h000000ff);
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000001);
      rx_send(8'h3c);
      repeat (5) @(posedge mclk_in);
      @(negedge mclk_in);
      check("no tick", pins_out, 8'h00);
      @(posedge mclk_in);
      ref_tick_in <= 1'b1;
      @(posedge mclk_in);
      ref_tick_in <= 1'b0;
      repeat (3) @(negedge mclk_in);
      check("ticked", pins_out, 8'h3c);
      repeat (4) begin
         @(posedge mclk_in);
         ref_tick_in <= 1'b1;
         @(posedge mclk_in);
         ref_tick_in <= 1'b0;
      end
      @(negedge mclk_in);
      check("held", pins_out, 8'h3c);
   endtask : t_async
   task automatic t_engine();
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000000);
      axi_wr(bitmode_pkg::ADDR_MODE, 32'h00000002);
      returned_clock_en <= 1'b0;
      axi_wr(bitmode_pkg::ADDR_ENGCFG, 32'h00000001);
      rx_send(8'h8b);
      repeat (5) @(negedge mclk_in);
      check("cmd byte", last_cmd, 8'h8b);
      check("engine oe", pins_oe_out, 8'h00);
      check("clock held", {serial_clock_out, serial_data_out}, 2'b10);
      @(posedge mclk_in);
      returned_clock_en <= 1'b1;
      repeat (6) @(negedge mclk_in);
      check("data released", serial_data_out, 1'b1);
   endtask : t_engine
   initial begin
      rst_n_in = 1'b0;
      {ref_tick_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rx_valid_in, tx_ready_in, s_axi_awaddr, s_axi_araddr, rx_data_in, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      ext = 8'ha5;
      returned_clock_en = 1'b1;
      last_cmd = 8'h00;
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      t_reset();
      t_modes();
      t_sync();
      t_async();
      t_engine();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_errors++;
      wrap_up();
   end
endmodule : serial_engine_bitbang_modes_tb
`default_nettype wire
